// ---- hw/bus_port_if.sv ----
// interface joining the host end and the peripheral end
// resolves the data bus itself from the two enables, device drive first
`timescale 1ns/1ps
interface bus_port_if;
  import bus_port_pkg::*;
  logic [ADDR_W-1:0] addr; // register address
  logic chip_select_n; // decoded select
  logic read_n; // read strobe
  logic write_n; // write strobe
  logic interrupt_acknowledge_n; // acknowledge cycle
  logic [DATA_W-1:0] host_data; // host data drive
  logic host_data_oe_n; // host drives when low
  logic [DATA_W-1:0] dev_data; // device data drive
  logic dev_data_oe_n; // device drives when low
  logic [DATA_W-1:0] bus_data; // resolved bus level
  logic int_n; // open-drain request, resolved
  logic int_oe_n; // device pulls low when low
  assign bus_data = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : '0);
  assign int_n = int_oe_n;
  modport host (output addr, chip_select_n, read_n, write_n, interrupt_acknowledge_n,
    host_data, host_data_oe_n, input bus_data, int_n);
  modport device (input addr, chip_select_n, read_n, write_n, interrupt_acknowledge_n,
    bus_data, output dev_data, dev_data_oe_n, int_oe_n);
endinterface : bus_port_if

// ---- hw/bus_port_pkg.sv ----
// package for the parallel host port and interrupt acknowledge handshake
// assumes one 40 MHz clock shared by both ends; strobes cross as async pins
package bus_port_pkg;
  localparam int DATA_W = 8; // data bus width
  localparam int ADDR_W = 2; // register address width
  localparam int REG_N = 4; // register count in the device
  localparam logic [7:0] VECTOR_RST = 8'h00; // vector register reset value
  localparam logic [1:0] ADDR_VECTOR = 2'h0; // vector register
  localparam logic [1:0] ADDR_CMD = 2'h1; // command register
  localparam logic [7:0] CMD_CLR_IP = 8'h01; // command bit: clear pending
  localparam logic [7:0] CMD_CLR_IUS = 8'h02; // command bit: clear under service
  localparam logic [3:0] HOST_WAIT = 4'h4; // last strobe count; strobe is low HOST_WAIT + 1 clocks
  localparam logic [4:0] SYNC_IDLE = 5'h1F; // synchroniser reset: every pin idle high
  // host cycle states
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_SETUP = 5'b00010,
    H_STROBE = 5'b00100,
    H_HOLD = 5'b01000,
    H_RESET = 5'b10000
  } host_state_t;
endpackage : bus_port_pkg

// ---- hw/host_port.sv ----
// host end: processor plus decode glue making write, read and ack cycles
// assumes same clock as the peripheral; int_n is sampled by two flops
`timescale 1ns/1ps
module host_port
  import bus_port_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic resetn_in, // async reset, active low
  bus_port_if.host bus, // peripheral side
  input wire logic req_valid_in, // start a cycle
  input wire logic [1:0] req_kind_in, // 0 write, 1 read, 2 ack, 3 reset
  input wire logic [ADDR_W-1:0] req_addr_in, // register address
  input wire logic [DATA_W-1:0] req_data_in, // write data
  input wire logic io_request_n_in, // processor io request, active low
  output logic req_ready_out, // idle, cycle accepted
  output logic [DATA_W-1:0] rsp_data_out, // read or vector data
  output logic rsp_valid_out, // read data pulse
  output logic int_pending_out // synchronised request level
);
  host_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d; // strobe time counter
  logic [1:0] kind_q, kind_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] data_q, data_d, rsp_q, rsp_d;
  logic rv_q, rv_d;
  logic [1:0] int_s_q, int_s_d; // int synchroniser

  // cycle sequencer next values
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    kind_d = kind_q;
    addr_d = addr_q;
    data_d = data_q;
    rsp_d = rsp_q;
    rv_d = 1'b0;
    int_s_d = {int_s_q[0], bus.int_n}; // request pin into the first stage
    unique case (st_q)
      H_IDLE: begin
        if (req_valid_in) begin
          kind_d = req_kind_in;
          addr_d = req_addr_in;
          data_d = req_data_in;
          st_d = (req_kind_in == 2'd3) ? H_RESET : H_SETUP;
          cnt_d = '0;
        end
      end
      H_SETUP: st_d = H_STROBE; // [R01] [R03] address, data first
      H_STROBE: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == HOST_WAIT) begin // [R10] same wait for read and write
          rsp_d = bus.bus_data;
          rv_d = (kind_q != 2'd0);
          st_d = H_HOLD;
        end
      end
      H_HOLD: st_d = H_IDLE;
      H_RESET: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == HOST_WAIT) begin
          st_d = H_IDLE;
        end
      end
      default: st_d = H_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= H_IDLE;
      cnt_q <= '0;
      kind_q <= '0;
      addr_q <= '0;
      data_q <= '0;
      rsp_q <= '0;
      rv_q <= 1'b0;
      int_s_q <= 2'h3;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      kind_q <= kind_d;
      addr_q <= addr_d;
      data_q <= data_d;
      rsp_q <= rsp_d;
      rv_q <= rv_d;
      int_s_q <= int_s_d;
    end
  end

  // pin drives
  assign bus.addr = addr_q; // [R01]
  assign bus.host_data = data_q;
  assign bus.host_data_oe_n = !(kind_q == 2'd0 && st_q != H_IDLE); // [R03]
  // select is io request qualified by an active cycle, no address decode, off in ack
  assign bus.chip_select_n = !(st_q != H_IDLE && kind_q != 2'd2 && !io_request_n_in); // [R09]
  assign bus.interrupt_acknowledge_n = !(st_q != H_IDLE && kind_q == 2'd2); // [R01]
  assign bus.write_n = !((st_q == H_STROBE && kind_q == 2'd0) || st_q == H_RESET);
  assign bus.read_n = !((st_q == H_STROBE && kind_q != 2'd0) || st_q == H_RESET);
  assign req_ready_out = (st_q == H_IDLE);
  assign rsp_data_out = rsp_q;
  assign rsp_valid_out = rv_q;
  assign int_pending_out = !int_s_q[1];
endmodule : host_port

// ---- hw/periph_port.sv ----
// peripheral end: register writes, pending and under-service flags, vector
// assumes host strobes are asynchronous; all of them pass two flip-flops
// Notes on behaviour
// R01: host keeps address and acknowledge steady
// R02: write counts only while select and strobe
// R03: host sets data before write strobe falls
// R04: no new request during acknowledge cycle
// R05: pending flag set on service conditions
// R06: acknowledge never clears pending by itself
// R07: acknowledge plus read drives vector
// R08: only highest priority device answers acknowledge
// R09: host select is address qualified by request; the host here qualifies only the active cycle, with no address decode
// R10: host uses equal read and write waits
// R11: drive bus only during read or acknowledge
// R12: read and write together reset chip
// R13: low chain enable blocks vector and flag
// R14: under service cleared only by command; the peripheral here also clears it on chip reset
`timescale 1ns/1ps
module periph_port
  import bus_port_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic resetn_in, // async reset, active low
  bus_port_if.device bus, // host side
  input wire logic chain_enable_in, // daisy chain enable from above
  output logic chain_enable_out, // daisy chain enable to below
  input wire logic event_in, // condition needing service, pulse
  input wire logic done_in, // causing action completed, pulse
  output logic interrupt_pending_flag_out, // pending flag
  output logic under_service_flag_out, // under service flag
  output logic chip_reset_out // chip reset, high for as long as both synced strobes are low
);
  // synchroniser stages for async pins
  logic [4:0] sync1_q, sync1_d; // first stage, may go metastable
  logic [4:0] sync2_q, sync2_d; // second stage, the only one read
  logic cs_n_s; // synced chip select
  logic rd_n_s; // synced read strobe
  logic wr_n_s; // synced write strobe
  logic ack_n_s; // synced acknowledge
  logic iei_s; // synced daisy chain enable
  // decoded cycle kinds, from synced levels only
  logic wr_eff; // effective write: select and write strobe overlap
  logic rd_ack; // acknowledge read in progress
  logic rd_reg; // plain register read in progress
  logic answer; // this device answers the acknowledge
  logic wr_end; // last cycle of an effective write
  // write path registers
  logic wr_act_q, wr_act_d; // write cycle active
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d; // address taken at write start
  logic [DATA_W-1:0] wr_data_q, wr_data_d; // data taken at write start
  logic [DATA_W-1:0] vector_q, vector_d; // vector register
  // flags
  logic ip_q, ip_d; // pending
  logic ius_q, ius_d; // under service
  logic ack_seen_q, ack_seen_d; // acknowledge read already taken
  logic rst_q, rst_d; // reset pulse
  // bus drive
  logic [DATA_W-1:0] dout_q, dout_d; // data drive
  logic oe_n_q, oe_n_d; // data enable, low drives

  // synchroniser next values: pins into stage one, stage one into two
  always_comb begin
    sync1_d = {chain_enable_in, bus.interrupt_acknowledge_n, bus.write_n,
      bus.read_n, bus.chip_select_n};
    sync2_d = sync1_q;
  end
  // synchroniser registers, reset to the idle level of every pin
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end
  // synced levels, taken only from the second stage
  assign cs_n_s = sync2_q[0];
  assign rd_n_s = sync2_q[1];
  assign wr_n_s = sync2_q[2];
  assign ack_n_s = sync2_q[3];
  assign iei_s = sync2_q[4];

  // cycle decode; both strobes low decodes to no transfer at all
  assign wr_eff = !cs_n_s && !wr_n_s && rd_n_s; // [R02]
  assign rd_ack = !ack_n_s && !rd_n_s && wr_n_s; // [R07]
  assign rd_reg = !cs_n_s && !rd_n_s && wr_n_s && ack_n_s; // [R11]
  assign answer = rd_ack && iei_s && ip_q; // [R08] [R13]
  // late select or early deselect ends the effective write here
  assign wr_end = wr_act_q && !wr_eff; // [R02]

  // write path next values
  // the synced strobe ends two clocks after the pin does, when the host
  // has already let go of the bus, so address and data are taken early
  always_comb begin
    wr_act_d = wr_eff;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    vector_d = vector_q;
    // first cycle of the write: data was set up before the strobe fell
    if (wr_eff && !wr_act_q) begin
      wr_addr_d = bus.addr; // [R02] held steady by the host
      wr_data_d = bus.bus_data; // [R02] valid since before the strobe
    end
    // commit to the vector register when the effective cycle ends
    if (wr_end && wr_addr_q == ADDR_VECTOR) begin
      vector_d = wr_data_q; // [R02]
    end
    // chip reset restores the vector
    if (rst_q) begin
      vector_d = VECTOR_RST; // [R12]
    end
  end
  // write path registers
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_act_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      vector_q <= VECTOR_RST;
    end else begin
      wr_act_q <= wr_act_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      vector_q <= vector_d;
    end
  end

  // flag next values; later assignments take priority
  always_comb begin
    ip_d = ip_q;
    ius_d = ius_q;
    ack_seen_d = rd_ack; // remembers that this acknowledge already counted
    rst_d = !rd_n_s && !wr_n_s; // [R12]
    // command write clears flags at the end of the effective cycle
    if (wr_end && wr_addr_q == ADDR_CMD) begin
      // clear pending on command
      if ((wr_data_q & CMD_CLR_IP) != '0) begin
        ip_d = 1'b0; // [R06]
      end
      // clear under service on command; chip reset is the only other way out
      if ((wr_data_q & CMD_CLR_IUS) != '0) begin
        ius_d = 1'b0; // [R14]
      end
    end
    // causing action completed
    if (done_in) begin
      ip_d = 1'b0; // [R06]
    end
    // new events held off while acknowledge in progress; set beats done and command clears
    if (event_in && ack_n_s) begin
      ip_d = 1'b1; // [R04] [R05]
    end
    // first cycle of an answered acknowledge marks under service once
    if (answer && !ack_seen_q) begin
      ius_d = 1'b1; // [R08]
    end
    // chip reset clears both flags
    if (rst_q) begin
      ip_d = 1'b0; // [R12]
      ius_d = 1'b0; // [R12]
    end
  end
  // flag registers
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ip_q <= 1'b0;
      ius_q <= 1'b0;
      ack_seen_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      ip_q <= ip_d;
      ius_q <= ius_d;
      ack_seen_q <= ack_seen_d;
      rst_q <= rst_d;
    end
  end

  // bus drive next values; released unless a read is in progress
  always_comb begin
    oe_n_d = 1'b1;
    dout_d = dout_q;
    if (answer) begin
      // acknowledge read: vector onto the bus
      oe_n_d = 1'b0; // [R07] [R11]
      dout_d = vector_q;
    end else if (rd_reg) begin
      // register read: vector or status
      oe_n_d = 1'b0; // [R11]
      dout_d = (bus.addr == ADDR_VECTOR) ? vector_q :
        {{(DATA_W-2){1'b0}}, ius_q, ip_q};
    end
    // nothing driven during chip reset
    if (rst_q) begin
      oe_n_d = 1'b1; // [R12]
    end
  end
  // bus drive registers, so the pins never glitch
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dout_q <= '0;
      oe_n_q <= 1'b1;
    end else begin
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
    end
  end

  // outputs
  assign bus.dev_data = dout_q; // registered data drive
  assign bus.dev_data_oe_n = oe_n_q; // registered enable
  assign bus.int_oe_n = !(ip_q && !ius_q && iei_s); // request only when enabled
  // lower chain blocked while under service, or while pending in acknowledge
  assign chain_enable_out = iei_s && !ius_q && !(ip_q && !ack_n_s); // [R08]
  assign interrupt_pending_flag_out = ip_q; // pending level
  assign under_service_flag_out = ius_q; // under service level
  assign chip_reset_out = rst_q; // high for as long as both synced strobes are low, one clock after they fall
endmodule : periph_port

// ---- tb/bus_port_props.sv ----
// checker for the host end and peripheral end across the bus interface
// assumes the bench hands in the interface signals by name
`timescale 1ns/1ps
module bus_port_props
  import bus_port_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic [ADDR_W-1:0] addr, // register address
  input wire logic chip_select_n, // decoded select
  input wire logic read_n, // read strobe
  input wire logic write_n, // write strobe
  input wire logic interrupt_acknowledge_n, // acknowledge cycle
  input wire logic host_data_oe_n, // host drives when low
  input wire logic dev_data_oe_n, // device drives when low
  input wire logic int_oe_n // device pulls request low
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // device starts driving only inside a read strobe
  drive_in_read_a: assert property ($fell(dev_data_oe_n) |-> !read_n)
    else $error("device drive began outside read");
  // no select and no acknowledge for a while: bus released
  bus_quiet_a: assert property (chip_select_n && interrupt_acknowledge_n &&
    $past(chip_select_n, 4) && $past(interrupt_acknowledge_n, 4) |-> dev_data_oe_n)
    else $error("device drives an idle bus");
  // acknowledge settled for a while: no new request appears
  no_new_req_a: assert property (!interrupt_acknowledge_n &&
    !$past(interrupt_acknowledge_n, 5) |-> !$fell(int_oe_n))
    else $error("new request during acknowledge");
  // read and write together clear the pending request
  reset_drops_a: assert property (!read_n && !write_n |-> ##[1:8] int_oe_n)
    else $error("chip reset left request active");
  // vector only from a device that was requesting
  vector_owner_a: assert property ($fell(dev_data_oe_n) && !interrupt_acknowledge_n
    |-> !$past(int_oe_n, 3))
    else $error("vector driven without request");
  // address and acknowledge steady through a write
  addr_steady_a: assert property (!write_n && !$past(write_n)
    |-> $stable(addr) && $stable(interrupt_acknowledge_n))
    else $error("address moved during write");
  // host data on the bus before the write strobe falls
  data_first_a: assert property ($fell(write_n) && read_n
    |-> !host_data_oe_n && !$past(host_data_oe_n))
    else $error("write data late");
  // equal strobe widths for read and write
  write_width_a: assert property ($fell(write_n) |-> (!write_n)[*5] ##1 write_n)
    else $error("write strobe width wrong");
  read_width_a: assert property ($fell(read_n) |-> (!read_n)[*5] ##1 read_n)
    else $error("read strobe width wrong");
endmodule : bus_port_props

// ---- tb/peripheral_bus_interrupt_acknowledge_n_port_tb.sv ----
// bench joining host end and peripheral end through the bus interface
// assumes one 40 MHz clock; host cycles spaced as the host allows
`timescale 1ns/1ps
module peripheral_bus_interrupt_acknowledge_n_port_tb;
  import bus_port_pkg::*;
  logic ref_clk_in = 1'b0; // clock
  logic resetn_in = 1'b0; // reset, active low
  logic req_valid_in = 1'b0; // host request strobe
  logic [1:0] req_kind_in = 2'h0; // request kind
  logic [ADDR_W-1:0] req_addr_in = '0; // request address
  logic [DATA_W-1:0] req_data_in = '0; // request data
  logic io_request_n_in = 1'b0; // active except in the select test
  logic chain_enable_in = 1'b1; // daisy enable in
  logic event_in = 1'b0; // service condition
  logic done_in = 1'b0; // cause completed
  logic req_ready_out, rsp_valid_out, int_pending_out, chain_enable_out; // host/chain outs
  logic interrupt_pending_flag_out, under_service_flag_out, chip_reset_out; // flags
  logic [DATA_W-1:0] rsp_data_out; // read or vector data
  int miscompares = 0; // mismatches
  int check_count = 0; // comparisons
  int cyc = 0; // timeout counter
  int rv_seen = 0; // read and vector response pulses seen in the current cycle
  int rst_seen = 0; // chip reset cycles seen in the current cycle
  bus_port_if bus_i();
  host_port host_port_i(.ref_clk_in, .resetn_in, .bus(bus_i), .req_valid_in, .req_kind_in,
    .req_addr_in, .req_data_in, .io_request_n_in, .req_ready_out, .rsp_data_out,
    .rsp_valid_out, .int_pending_out);
  periph_port periph_port_i(.ref_clk_in, .resetn_in, .bus(bus_i), .chain_enable_in,
    .chain_enable_out, .event_in, .done_in, .interrupt_pending_flag_out,
    .under_service_flag_out, .chip_reset_out);
  bus_port_props bus_port_props_i(.ref_clk_in, .resetn_in, .addr(bus_i.addr),
    .chip_select_n(bus_i.chip_select_n), .read_n(bus_i.read_n), .write_n(bus_i.write_n),
    .interrupt_acknowledge_n(bus_i.interrupt_acknowledge_n),
    .host_data_oe_n(bus_i.host_data_oe_n), .dev_data_oe_n(bus_i.dev_data_oe_n),
    .int_oe_n(bus_i.int_oe_n));
  always #12.5 ref_clk_in = ~ref_clk_in;
  // closing report
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  // hang guard
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end
  // counts response and chip reset pulses where they are settled
  always @(negedge ref_clk_in) begin
    if (rsp_valid_out === 1'b1) begin
      rv_seen++;
    end
    if (chip_reset_out === 1'b1) begin
      rst_seen++;
    end
  end
  task automatic check(input string n, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : check
  // one host cycle; optional event pulse at cycle ev after accept
  task automatic req(input logic [1:0] k, input logic [1:0] a, input logic [7:0] d,
    input int ev);
    do @(negedge ref_clk_in); while (req_ready_out !== 1'b1);
    @(posedge ref_clk_in);
    rv_seen = 0;
    rst_seen = 0;
    req_valid_in <= 1'b1;
    req_kind_in <= k;
    req_addr_in <= a;
    req_data_in <= d;
    @(posedge ref_clk_in);
    req_valid_in <= 1'b0;
    for (int i = 1; i < 12; i++) begin
      @(posedge ref_clk_in);
      event_in <= (i == ev);
    end
    check("rsp valid", 8'(rv_seen), {7'h00, (k == 2'h1 || k == 2'h2)});
  endtask : req
  // pulse event (w 0) or done (w 1)
  task automatic pulse(input int w);
    @(posedge ref_clk_in);
    event_in <= (w == 0);
    done_in <= (w == 1);
    @(posedge ref_clk_in);
    event_in <= 1'b0;
    done_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
  endtask : pulse
  task automatic flags(input logic ip, input logic under_service_flag);
    @(negedge ref_clk_in);
    check("pending", {7'h00, interrupt_pending_flag_out}, {7'h00, ip});
    check("service", {7'h00, under_service_flag_out}, {7'h00, under_service_flag});
  endtask : flags
  task automatic t_wr_rd;
    req(2'h0, ADDR_VECTOR, 8'hA5, 0);
    req(2'h1, ADDR_VECTOR, 8'h00, 0);
    check("vector read", rsp_data_out, 8'hA5);
    $display("test wr_rd done");
  endtask : t_wr_rd
  task automatic t_ack;
    pulse(0);
    flags(1'b1, 1'b0);
    check("request pin", {7'h00, int_pending_out}, 8'h01);
    req(2'h2, 2'h0, 8'h00, 0);
    check("ack vector", rsp_data_out, 8'hA5);
    flags(1'b1, 1'b1);
    check("chain out busy", {7'h00, chain_enable_out}, 8'h00);
    check("request masked", {7'h00, int_pending_out}, 8'h00);
    req(2'h1, ADDR_CMD, 8'h00, 0);
    check("status read", rsp_data_out, 8'h03);
    req(2'h0, ADDR_CMD, CMD_CLR_IUS, 0);
    flags(1'b1, 1'b0);
    check("chain out free", {7'h00, chain_enable_out}, 8'h01);
    pulse(1);
    flags(1'b0, 1'b0);
    pulse(0);
    req(2'h0, ADDR_CMD, CMD_CLR_IP, 0);
    flags(1'b0, 1'b0);
    $display("test ack done");
  endtask : t_ack
  task automatic t_busy;
    req(2'h2, 2'h0, 8'h00, 4);
    check("idle ack bus", rsp_data_out, 8'h00);
    flags(1'b0, 1'b0);
    $display("test busy done");
  endtask : t_busy
  task automatic t_chain;
    @(posedge ref_clk_in);
    chain_enable_in <= 1'b0;
    pulse(0);
    req(2'h2, 2'h0, 8'h00, 0);
    check("blocked ack bus", rsp_data_out, 8'h00);
    flags(1'b1, 1'b0);
    check("chain out blocked", {7'h00, chain_enable_out}, 8'h00);
    @(posedge ref_clk_in);
    chain_enable_in <= 1'b1;
    $display("test chain done");
  endtask : t_chain
  task automatic t_reset;
    req(2'h0, ADDR_VECTOR, 8'h3C, 0);
    req(2'h3, 2'h0, 8'h00, 0);
    check("reset pulse", 8'(rst_seen), {4'h0, HOST_WAIT + 4'h1});
    flags(1'b0, 1'b0);
    req(2'h1, ADDR_VECTOR, 8'h00, 0);
    check("vector after reset", rsp_data_out, VECTOR_RST);
    $display("test reset done");
  endtask : t_reset
  // write with io request idle: no select, so the vector keeps its value
  task automatic t_select;
    @(posedge ref_clk_in);
    io_request_n_in <= 1'b1;
    req(2'h0, ADDR_VECTOR, 8'h5A, 0);
    @(posedge ref_clk_in);
    io_request_n_in <= 1'b0;
    req(2'h1, ADDR_VECTOR, 8'h00, 0);
    check("unselected write", rsp_data_out, VECTOR_RST);
    $display("test select done");
  endtask : t_select
  initial begin
    repeat (6) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    t_wr_rd();
    t_ack();
    t_busy();
    t_chain();
    t_reset();
    t_select();
    results();
  end
endmodule : peripheral_bus_interrupt_acknowledge_n_port_tb
